// ==== shared/dsp_pkg.sv ====
// What this block does
// - Block splits into eight 9x9, four 18x18 or one 36x36 multiplier.
// - The 36x36 product is exact for signed, unsigned and mixed operands.
// - Products go to the adder, to the accumulator or straight out.
// - Results may be rounded and saturated as Q1.15 fixed point.
// - Four functions: simple, multiply-accumulate, two-adder, four-adder.
// - Simple mode gives one product output per configured multiplier.
// - Adder modes exist at 9x9 and 18x18 only, never at 36x36.
// - Lower and upper halves pick function and size independently.
// - Operand registers chain as a shift register down the column.
// - The shift chain leaves the block to continue in another column.
// - Four units, each a full 18x18 multiplier, 36 bits in and out.
// - Each row has its own clear and enable for its registers.
// - Operand signedness comes from run-time inputs.
// - Each pair adds or subtracts as its run-time input says.
// - Rounding and clamping act only when their inputs are high.
// - Running total load replaces the total instead of adding to it.
package dsp_pkg;
  localparam int UNIT_WIDTH = 18;
  localparam int ACC_WIDTH = 52;
  localparam logic [11:0] CONFIG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] CONFIG_MASK = 32'h0000FF7F;
  localparam int LOW_FN_LSB = 0;
  localparam int HIGH_FN_LSB = 2;
  localparam int LOW_SIZE_BIT = 4;
  localparam int HIGH_SIZE_BIT = 5;
  localparam int WIDE_BIT = 6;
  localparam int SOURCE_LSB = 8;
  localparam logic [1:0] SEL_SIMPLE = 2'h0;
  localparam logic [1:0] SEL_MAC = 2'h1;
  localparam logic [1:0] SEL_ADD2 = 2'h2;
  localparam logic [1:0] SEL_ADD4 = 2'h3;
  localparam logic signed [51:0] Q15_HALF = 52'sh0000000004000;
  localparam logic signed [51:0] Q15_KEEP = 52'shFFFFFFFFF8000;
  localparam logic signed [51:0] Q15_MAX = 52'sh000003FFF8000;
  localparam logic signed [51:0] Q15_MIN = 52'shFFFFFC0000000;

  typedef enum logic [3:0] {
    FN_SIMPLE = 4'h1,
    FN_MAC = 4'h2,
    FN_ADD2 = 4'h4,
    FN_ADD4 = 4'h8
  } function_t;

  // Values carry 30 fraction bits, the scale of a Q1.15 by Q1.15 product
  function automatic logic signed [51:0] q15_fix(
    input logic signed [51:0] v,
    input logic rnd,
    input logic sat
  );
    logic signed [51:0] r;
    r = v;
    if (rnd) begin
      r = (v + Q15_HALF) & Q15_KEEP;
    end
    if (sat && r > Q15_MAX) begin
      r = Q15_MAX;
    end else if (sat && r < Q15_MIN) begin
      r = Q15_MIN;
    end
    return r;
  endfunction
endpackage

// ==== rtl/mult_unit.sv ====
`timescale 1ns/1ps
module mult_unit #(
  parameter int W = dsp_pkg::UNIT_WIDTH
) (
  input logic clk,
  input logic rst_n,
  input logic gate,
  input logic a_from_chain,
  input logic b_from_chain,
  input logic [W-1:0] a_in,
  input logic [W-1:0] b_in,
  input logic [W-1:0] a_chain_in,
  input logic [W-1:0] b_chain_in,
  input logic x_signed,
  input logic y_signed,
  output logic [W-1:0] a_q,
  output logic [W-1:0] b_q,
  output logic x_signed_q,
  output logic y_signed_q,
  output logic signed [2*W+1:0] prod_full,
  output logic signed [W+1:0] prod_hi,
  output logic signed [W+1:0] prod_lo
);
  localparam int H = W / 2;
  logic [W-1:0] next_a;
  logic [W-1:0] next_b;

  assign next_a = a_from_chain ? a_chain_in : a_in;
  assign next_b = b_from_chain ? b_chain_in : b_in;

  // The enable holds the registers instead of gating the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= '0;
      b_q <= '0;
      x_signed_q <= 1'b0;
      y_signed_q <= 1'b0;
    end else if (gate) begin
      a_q <= next_a;
      b_q <= next_b;
      x_signed_q <= x_signed;
      y_signed_q <= y_signed;
    end
  end

  // One 18x18 product and two 9x9 products from the same registers
  assign prod_full = $signed({x_signed_q & a_q[W-1], a_q})
    * $signed({y_signed_q & b_q[W-1], b_q});
  assign prod_hi = $signed({x_signed_q & a_q[W-1], a_q[W-1:H]})
    * $signed({y_signed_q & b_q[W-1], b_q[W-1:H]});
  assign prod_lo = $signed({x_signed_q & a_q[H-1], a_q[H-1:0]})
    * $signed({y_signed_q & b_q[H-1], b_q[H-1:0]});

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    !gate |=> $stable(a_q) && $stable(b_q);
  endproperty
  a_hold: assert property (p_hold) else $error("operands moved while held");

  property p_chain;
    @(posedge clk) disable iff (!rst_n)
    gate && a_from_chain |=> a_q == $past(a_chain_in);
  endproperty
  a_chain: assert property (p_chain) else $error("chain not shifted in");
endmodule

// ==== rtl/pair_stage.sv ====
`timescale 1ns/1ps
module pair_stage (
  input logic clk,
  input logic rst_n,
  input logic gate,
  input dsp_pkg::function_t fn,
  input logic size18,
  input logic signed [37:0] p0,
  input logic signed [37:0] p1,
  input logic signed [19:0] p0_hi,
  input logic signed [19:0] p0_lo,
  input logic signed [19:0] p1_hi,
  input logic signed [19:0] p1_lo,
  input logic add_sub,
  input logic prod_rnd,
  input logic prod_sat,
  input logic sum_rnd,
  input logic sum_sat,
  input logic load,
  output logic signed [51:0] sum18,
  output logic [51:0] acc,
  output logic [71:0] half_out
);
  logic signed [51:0] pp0;
  logic signed [51:0] pp1;
  logic signed [51:0] sum2;
  logic signed [20:0] s9_lo;
  logic signed [20:0] s9_hi;
  logic signed [21:0] s9_all;
  logic [51:0] next_acc;

  assign pp0 = dsp_pkg::q15_fix(52'(p0), prod_rnd, prod_sat);
  assign pp1 = dsp_pkg::q15_fix(52'(p1), prod_rnd, prod_sat);
  assign sum2 = add_sub ? pp0 + pp1 : pp0 - pp1;
  assign sum18 = dsp_pkg::q15_fix(sum2, sum_rnd, sum_sat);
  assign s9_lo = add_sub ? p0_lo + p1_lo : p0_lo - p1_lo;
  assign s9_hi = add_sub ? p0_hi + p1_hi : p0_hi - p1_hi;
  assign s9_all = s9_lo + s9_hi;
  assign next_acc = load ? sum18 : acc + sum18;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
    end else if (gate && fn == dsp_pkg::FN_MAC) begin
      acc <= next_acc;
    end
  end

  always_comb begin
    case (fn)
      dsp_pkg::FN_SIMPLE: begin
        half_out = size18 ? {pp1[35:0], pp0[35:0]}
          : {p1_hi[17:0], p1_lo[17:0], p0_hi[17:0], p0_lo[17:0]};
      end
      dsp_pkg::FN_MAC: begin
        half_out = {{20{acc[51]}}, acc};
      end
      dsp_pkg::FN_ADD2: begin
        half_out = size18 ? 72'(sum18) : {36'(s9_hi), 36'(s9_lo)};
      end
      dsp_pkg::FN_ADD4: begin
        half_out = size18 ? 72'(sum18) : 72'(s9_all);
      end
      default: begin
        half_out = '0;
      end
    endcase
  end

  property p_load;
    @(posedge clk) disable iff (!rst_n)
    load && gate && fn == dsp_pkg::FN_MAC |=> acc == $past(sum18);
  endproperty
  a_load: assert property (p_load) else $error("total not loaded");

  property p_accum;
    @(posedge clk) disable iff (!rst_n)
    !load && gate && fn == dsp_pkg::FN_MAC
      |=> acc == 52'($past(acc) + $past(sum18));
  endproperty
  a_accum: assert property (p_accum) else $error("total not summed");
endmodule

// ==== rtl/dsp_block.sv ====
`timescale 1ns/1ps
module dsp_block (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [3:0] async_clear_row,
  input logic [3:0] clock_gate_row,
  input logic [17:0] operand_a [4],
  input logic [17:0] operand_b [4],
  input logic [17:0] cascade_a_in,
  input logic [17:0] cascade_b_in,
  output logic [17:0] cascade_a_out,
  output logic [17:0] cascade_b_out,
  input logic operand_x_is_signed,
  input logic operand_y_is_signed,
  input logic pair_low_add_or_subtract,
  input logic pair_high_add_or_subtract,
  input logic pair_low_product_rounding_on,
  input logic pair_high_product_rounding_on,
  input logic pair_low_product_clamp_on,
  input logic pair_high_product_clamp_on,
  input logic pair_low_sum_rounding_on,
  input logic pair_high_sum_rounding_on,
  input logic pair_low_sum_clamp_on,
  input logic pair_high_sum_clamp_on,
  input logic running_total_load_low,
  input logic running_total_load_high,
  output logic [71:0] result_low_half,
  output logic [71:0] result_high_half
);
  logic [31:0] config_word;
  logic [31:0] next_prdata;
  logic [3:0] row_rst_n;
  logic [17:0] a_q [4];
  logic [17:0] b_q [4];
  logic [17:0] a_chain [4];
  logic [17:0] b_chain [4];
  logic [3:0] x_sq;
  logic [3:0] y_sq;
  logic signed [37:0] p18 [4];
  logic signed [19:0] p9_hi [4];
  logic signed [19:0] p9_lo [4];
  logic signed [51:0] sum_low;
  logic signed [51:0] sum_high;
  logic [51:0] acc_low;
  logic [51:0] acc_high;
  logic [71:0] half_low;
  logic [71:0] half_high;
  logic [71:0] next_low;
  logic [71:0] next_high;
  logic signed [73:0] prod36;
  logic signed [52:0] sum_both;
  dsp_pkg::function_t fn_low;
  dsp_pkg::function_t fn_high;

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_config = paddr == dsp_pkg::CONFIG_OFFSET;
  wire hit_status = paddr == dsp_pkg::STATUS_OFFSET;
  wire mapped = hit_config | hit_status;
  wire write_config = access & pwrite & hit_config;
  wire wide = config_word[dsp_pkg::WIDE_BIT];
  wire size_low = config_word[dsp_pkg::LOW_SIZE_BIT];
  wire size_high = config_word[dsp_pkg::HIGH_SIZE_BIT];
  wire [1:0] sel_low = config_word[dsp_pkg::LOW_FN_LSB +: 2];
  wire [1:0] sel_high = config_word[dsp_pkg::HIGH_FN_LSB +: 2];
  wire [7:0] sources = config_word[dsp_pkg::SOURCE_LSB +: 8];
  wire wide_add4 = fn_low == dsp_pkg::FN_ADD4
    && fn_high == dsp_pkg::FN_ADD4 && size_low && size_high;

  // Forbidden pairings fall back to simple mode rather than misbehave
  function automatic dsp_pkg::function_t pick_fn(
    input logic [1:0] sel,
    input logic size18,
    input logic whole
  );
    dsp_pkg::function_t f;
    f = dsp_pkg::FN_SIMPLE;
    if (!whole) begin
      if (sel == dsp_pkg::SEL_MAC && size18) begin
        f = dsp_pkg::FN_MAC;
      end else if (sel == dsp_pkg::SEL_ADD2) begin
        f = dsp_pkg::FN_ADD2;
      end else if (sel == dsp_pkg::SEL_ADD4) begin
        f = dsp_pkg::FN_ADD4;
      end
    end
    return f;
  endfunction

  assign fn_low = pick_fn(sel_low, size_low, wide);
  assign fn_high = pick_fn(sel_high, size_high, wide);

  // Zero-wait slave: the answer is prepared during the setup cycle
  assign next_prdata = hit_config ? config_word
    : hit_status ? {23'h000000, wide, fn_high, fn_low}
    : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? next_prdata : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_word <= dsp_pkg::CONFIG_RESET;
    end else if (write_config) begin
      config_word <= pwdata & dsp_pkg::CONFIG_MASK;
    end
  end

  // A row clear is a second reset source for that row only
  assign row_rst_n = {4{presetn}} & ~async_clear_row;

  assign a_chain[0] = cascade_a_in;
  assign b_chain[0] = cascade_b_in;

  for (genvar k = 0; k < 4; k++) begin : g_unit
    if (k > 0) begin : g_link
      assign a_chain[k] = a_q[k-1];
      assign b_chain[k] = b_q[k-1];
    end
    mult_unit #(
      .W(dsp_pkg::UNIT_WIDTH)
    ) u_unit (
      .clk(pclk),
      .rst_n(row_rst_n[k]),
      .gate(clock_gate_row[k]),
      .a_from_chain(sources[2*k]),
      .b_from_chain(sources[2*k+1]),
      .a_in(operand_a[k]),
      .b_in(operand_b[k]),
      .a_chain_in(a_chain[k]),
      .b_chain_in(b_chain[k]),
      .x_signed(operand_x_is_signed),
      .y_signed(operand_y_is_signed),
      .a_q(a_q[k]),
      .b_q(b_q[k]),
      .x_signed_q(x_sq[k]),
      .y_signed_q(y_sq[k]),
      .prod_full(p18[k]),
      .prod_hi(p9_hi[k]),
      .prod_lo(p9_lo[k])
    );
  end

  // The chain leaves from the last unit's registers
  assign cascade_a_out = a_q[3];
  assign cascade_b_out = b_q[3];

  pair_stage u_pair_low (
    .clk(pclk),
    .rst_n(row_rst_n[1]),
    .gate(clock_gate_row[1]),
    .fn(fn_low),
    .size18(size_low),
    .p0(p18[0]),
    .p1(p18[1]),
    .p0_hi(p9_hi[0]),
    .p0_lo(p9_lo[0]),
    .p1_hi(p9_hi[1]),
    .p1_lo(p9_lo[1]),
    .add_sub(pair_low_add_or_subtract),
    .prod_rnd(pair_low_product_rounding_on),
    .prod_sat(pair_low_product_clamp_on),
    .sum_rnd(pair_low_sum_rounding_on),
    .sum_sat(pair_low_sum_clamp_on),
    .load(running_total_load_low),
    .sum18(sum_low),
    .acc(acc_low),
    .half_out(half_low)
  );

  pair_stage u_pair_high (
    .clk(pclk),
    .rst_n(row_rst_n[3]),
    .gate(clock_gate_row[3]),
    .fn(fn_high),
    .size18(size_high),
    .p0(p18[2]),
    .p1(p18[3]),
    .p0_hi(p9_hi[2]),
    .p0_lo(p9_lo[2]),
    .p1_hi(p9_hi[3]),
    .p1_lo(p9_lo[3]),
    .add_sub(pair_high_add_or_subtract),
    .prod_rnd(pair_high_product_rounding_on),
    .prod_sat(pair_high_product_clamp_on),
    .sum_rnd(pair_high_sum_rounding_on),
    .sum_sat(pair_high_sum_clamp_on),
    .load(running_total_load_high),
    .sum18(sum_high),
    .acc(acc_high),
    .half_out(half_high)
  );

  // Wide product uses the two lower units; signs go on the upper words
  assign prod36 = $signed({x_sq[1] & a_q[1][17], a_q[1], a_q[0]})
    * $signed({y_sq[1] & b_q[1][17], b_q[1], b_q[0]});
  assign sum_both = sum_low + sum_high;

  assign next_low = wide ? prod36[71:0]
    : wide_add4 ? 72'(sum_both)
    : half_low;
  assign next_high = (wide | wide_add4) ? 72'h000000000000000000
    : half_high;

  // Plain output stage: one cycle past the operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_low_half <= '0;
      result_high_half <= '0;
    end else begin
      result_low_half <= next_low;
      result_high_half <= next_high;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready;
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready timing");

  property p_unmapped;
    setup && !mapped |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error answer");

  property p_config;
    write_config |=> config_word == ($past(pwdata) & dsp_pkg::CONFIG_MASK);
  endproperty
  a_config: assert property (p_config) else $error("config lost");

  property p_wide;
    wide |=> result_low_half == $past(prod36[71:0])
      && result_high_half == 72'h000000000000000000;
  endproperty
  a_wide: assert property (p_wide) else $error("wide product wrong");

  property p_simple18;
    !wide && fn_low == dsp_pkg::FN_SIMPLE && size_low
      && !pair_low_product_rounding_on && !pair_low_product_clamp_on
      |=> result_low_half == $past({p18[1][35:0], p18[0][35:0]});
  endproperty
  a_simple18: assert property (p_simple18) else $error("product wrong");

  property p_clamp;
    !wide && fn_low == dsp_pkg::FN_SIMPLE && size_low
      && pair_low_product_clamp_on
      |=> $signed(result_low_half[35:0]) <= 36'sh03FFF8000
      && $signed(result_low_half[35:0]) >= 36'shFC0000000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp exceeded");

  property p_mac_out;
    fn_low == dsp_pkg::FN_MAC |=> result_low_half[51:0] == $past(acc_low);
  endproperty
  a_mac_out: assert property (p_mac_out) else $error("total not shown");

  property p_mac_high;
    fn_high == dsp_pkg::FN_MAC
      |=> result_high_half[51:0] == $past(acc_high);
  endproperty
  a_mac_high: assert property (p_mac_high) else $error("high lost");

  property p_add4;
    wide_add4 |=> result_low_half == 72'($past(sum_both))
      && result_high_half == 72'h000000000000000000;
  endproperty
  a_add4: assert property (p_add4) else $error("four-adder wrong");

  property p_wide_only;
    wide |-> fn_low == dsp_pkg::FN_SIMPLE
      && fn_high == dsp_pkg::FN_SIMPLE;
  endproperty
  a_wide_only: assert property (p_wide_only) else $error("wide adder");

  property p_mac18;
    (fn_low != dsp_pkg::FN_MAC || size_low)
      && (fn_high != dsp_pkg::FN_MAC || size_high);
  endproperty
  a_mac18: assert property (p_mac18) else $error("total at 9x9");

  c_wide: cover property (wide ##1 !wide);
  c_mac_load: cover property (fn_low == dsp_pkg::FN_MAC
    && running_total_load_low ##1 !running_total_load_low);
  c_mixed: cover property (fn_low == dsp_pkg::FN_MAC
    && fn_high == dsp_pkg::FN_SIMPLE && !size_high);
  c_wide_add4: cover property (wide_add4);
endmodule

// ==== verif/user_logic_model.sv ====
`timescale 1ns/1ps
module user_logic_model (
  output logic [3:0] async_clear_row,
  output logic [3:0] clock_gate_row,
  output logic [17:0] operand_a [4],
  output logic [17:0] operand_b [4],
  output logic [17:0] cascade_a_in,
  output logic [17:0] cascade_b_in,
  output logic operand_x_is_signed,
  output logic operand_y_is_signed,
  output logic pair_low_add_or_subtract,
  output logic pair_high_add_or_subtract,
  output logic pair_low_product_rounding_on,
  output logic pair_high_product_rounding_on,
  output logic pair_low_product_clamp_on,
  output logic pair_high_product_clamp_on,
  output logic pair_low_sum_rounding_on,
  output logic pair_high_sum_rounding_on,
  output logic pair_low_sum_clamp_on,
  output logic pair_high_sum_clamp_on,
  output logic running_total_load_low,
  output logic running_total_load_high
);
  // Callers enter just after a rising edge, as registered fabric logic would
  task automatic ops(input int k, input logic [17:0] a, input logic [17:0] b);
    operand_a[k] <= a;
    operand_b[k] <= b;
  endtask
  task automatic ctl(input logic [13:0] c);
    {operand_x_is_signed, operand_y_is_signed,
     pair_low_add_or_subtract, pair_high_add_or_subtract,
     pair_low_product_rounding_on, pair_high_product_rounding_on,
     pair_low_product_clamp_on, pair_high_product_clamp_on,
     pair_low_sum_rounding_on, pair_high_sum_rounding_on,
     pair_low_sum_clamp_on, pair_high_sum_clamp_on,
     running_total_load_low, running_total_load_high} <= c;
  endtask
  task automatic rows(input logic [3:0] clr, input logic [3:0] gate);
    async_clear_row <= clr;
    clock_gate_row <= gate;
  endtask
  task automatic chain(input logic [17:0] a, input logic [17:0] b);
    cascade_a_in <= a;
    cascade_b_in <= b;
  endtask
  initial begin
    async_clear_row = 4'h0;
    clock_gate_row = 4'hF;
    cascade_a_in = 18'h00000;
    cascade_b_in = 18'h00000;
    for (int k = 0; k < 4; k++) begin
      operand_a[k] = 18'h00000;
      operand_b[k] = 18'h00000;
    end
    {operand_x_is_signed, operand_y_is_signed, pair_low_add_or_subtract,
     pair_high_add_or_subtract, pair_low_product_rounding_on,
     pair_high_product_rounding_on, pair_low_product_clamp_on,
     pair_high_product_clamp_on, pair_low_sum_rounding_on,
     pair_high_sum_rounding_on, pair_low_sum_clamp_on,
     pair_high_sum_clamp_on, running_total_load_low,
     running_total_load_high} = 14'h0000;
  end
endmodule

// ==== verif/dsp_multiply_accumulate_block_bench.sv ====
`timescale 1ns/1ps
module dsp_multiply_accumulate_block_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] async_clear_row, clock_gate_row;
  logic [17:0] operand_a [4];
  logic [17:0] operand_b [4];
  logic [17:0] cascade_a_in, cascade_b_in, cascade_a_out, cascade_b_out;
  logic operand_x_is_signed, operand_y_is_signed;
  logic pair_low_add_or_subtract, pair_high_add_or_subtract;
  logic pair_low_product_rounding_on, pair_high_product_rounding_on;
  logic pair_low_product_clamp_on, pair_high_product_clamp_on;
  logic pair_low_sum_rounding_on, pair_high_sum_rounding_on;
  logic pair_low_sum_clamp_on, pair_high_sum_clamp_on;
  logic running_total_load_low, running_total_load_high;
  logic [71:0] result_low_half, result_high_half, r1, r2;
  int n_mismatch = 0;
  int check_count = 0;

  user_logic_model farside_u (.*);
  dsp_block dut_u (.*);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so that the
  // next setup never assigns psel twice in one time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(72'(rd), 72'(exp));
    check(72'(err), 72'h0);
  endtask

  // Result registers follow new operands two edges later
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic load(input logic [31:0] cfg, input logic [13:0] c);
    apb(1'b1, 12'h000, cfg);
    farside_u.ctl(c);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(result_low_half, 72'h0);
    rd_chk(12'h000, 32'h00000000);
    rd_chk(12'h004, 32'h00000011);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 12'h000, 32'(f * 5) + 32'h30);
      rd_chk(12'h004, 32'(17 << f));
    end
    apb(1'b1, 12'h000, 32'h00000001);
    rd_chk(12'h004, 32'h00000011);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    rd_chk(12'h000, 32'h0000FF7F);
    rd_chk(12'h004, 32'h00000111);
    apb(1'b1, 12'h004, 32'h00000000);
    rd_chk(12'h000, 32'h0000FF7F);
    apb(1'b1, 12'h008, 32'h00000005);
    check(72'(err), 72'h1);
    apb(1'b0, 12'h008, 32'h00000000);
    check({rd, 8'(err)}, 72'h01);
    // Simple 18x18, unsigned then signed
    load(32'h00000030, 14'h0000);
    farside_u.ops(0, 18'h00003, 18'h00005);
    farside_u.ops(1, 18'h00007, 18'h00002);
    farside_u.ops(2, 18'h3FFFF, 18'h3FFFF);
    farside_u.ops(3, 18'h00001, 18'h00000);
    settle();
    check(result_low_half, {36'h00000000E, 36'h00000000F});
    check(result_high_half, {36'h0, 36'hFFFF80001});
    farside_u.ctl(14'h3000);
    settle();
    check(result_high_half, {36'h0, 36'h000000001});
    // Simple 9x9
    load(32'h00000000, 14'h0000);
    farside_u.ops(0, {9'h003, 9'h004}, {9'h005, 9'h006});
    farside_u.ops(1, 18'h00000, 18'h00000);
    settle();
    check(result_low_half, {36'h0, 18'h0000F, 18'h00018});
    // Low two-adder 9x9 beside high four-adder 9x9
    load(32'h0000000E, 14'h0C00);
    farside_u.ops(1, {9'h002, 9'h001}, {9'h003, 9'h007});
    settle();
    check(result_low_half, {36'h15, 36'h1F});
    check(result_high_half, 72'h7F802);
    // Two-multiplier adder 18x18: add, then subtract
    load(32'h00000032, 14'h0800);
    farside_u.ops(0, 18'h00003, 18'h00005);
    farside_u.ops(1, 18'h00007, 18'h00003);
    settle();
    check(result_low_half, 72'h24);
    farside_u.ctl(14'h0000);
    settle();
    check(result_low_half, 72'hFFFFFFFFFFFFFFFFFA);
    // Four-multiplier adder over both halves
    load(32'h0000003F, 14'h0C00);
    farside_u.ops(2, 18'h00001, 18'h00001);
    farside_u.ops(3, 18'h00002, 18'h00002);
    settle();
    check(result_low_half, 72'h29);
    check(result_high_half, 72'h0);
    // Multiply-accumulate: load, run, hold, clear
    load(32'h00000011, 14'h0802);
    settle();
    check(result_low_half, 72'h24);
    check(result_high_half, {18'h0, 18'h4, 18'h0, 18'h1});
    farside_u.ctl(14'h0800);
    settle();
    r1 = result_low_half;
    @(posedge pclk);
    r2 = result_low_half;
    check(r2 - r1, 72'h24);
    farside_u.rows(4'h0, 4'hD);
    settle();
    r1 = result_low_half;
    @(posedge pclk);
    check(result_low_half, r1);
    farside_u.rows(4'h2, 4'hD);
    settle();
    check(result_low_half, 72'h0);
    farside_u.rows(4'h0, 4'hF);
    // Upper accumulator: load, then run
    load(32'h00000024, 14'h0401);
    settle();
    check(result_high_half, 72'h5);
    farside_u.ctl(14'h0400);
    settle();
    r1 = result_high_half;
    @(posedge pclk);
    check(result_high_half - r1, 72'h5);
    // Q1.15 rounding and clamping of products
    load(32'h00000030, 14'h3000);
    farside_u.ops(0, 18'h38000, 18'h38000);
    farside_u.ops(1, 18'h00001, 18'h04000);
    settle();
    check(result_low_half, {36'h000004000, 36'h040000000});
    farside_u.ctl(14'h3280);
    settle();
    check(result_low_half, {36'h000008000, 36'h03FFF8000});
    // Same products summed with the sum rounded, then the sum also clamped
    load(32'h00000032, 14'h3820);
    settle();
    check(result_low_half, 72'h40008000);
    farside_u.ctl(14'h3828);
    settle();
    check(result_low_half, 72'h3FFF8000);
    // 36x36, unsigned, mixed sign and signed; wider arithmetic is left to fabric
    load(32'h00000040, 14'h0000);
    farside_u.ops(0, 18'h3FFFD, 18'h00005);
    farside_u.ops(1, 18'h3FFFF, 18'h00000);
    settle();
    check(result_low_half, 72'h4FFFFFFFF1);
    check(result_high_half, 72'h0);
    farside_u.ctl(14'h2000);
    settle();
    check(result_low_half, 72'hFFFFFFFFFFFFFFFFF1);
    farside_u.ctl(14'h3000);
    farside_u.ops(1, 18'h3FFFF, 18'h3FFFF);
    settle();
    check(result_low_half, 72'hBFFF1);
    // Shift chain through all four units and out
    load(32'h0000FF30, 14'h0000);
    farside_u.chain(18'h00005, 18'h00003);
    repeat (8) @(posedge pclk);
    check(result_high_half, {36'hF, 36'hF});
    farside_u.chain(18'h00007, 18'h00003);
    repeat (2) @(posedge pclk);
    check(72'(cascade_a_out), 72'h5);
    repeat (3) @(posedge pclk);
    check(72'({cascade_a_out, cascade_b_out}), 72'h1C0003);
    tally_and_finish();
  end
endmodule
